// [hdl/ccdl_loader.sv]
// dynamic configuration loader: serial shift register, apply logic and APB slave
`timescale 1ns/1ps
`default_nettype none
module ccdl_loader
    import ccdl_pkg::*;
#(
    parameter logic [CFG_BITS-1:0] FIXED_CONFIG = CFG_FIXED_DEFAULT
) (
    input  wire logic                CLOCK,
    input  wire logic                RSTN,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                SHIFT_CLOCK,
    input  wire logic                SERIAL_CONFIG_IN,
    input  wire logic                CONFIG_SHIFT_ENABLE,
    input  wire logic                CONFIG_APPLY_STROBE,
    input  wire logic                CONFIG_MODE_SELECT,
    output logic                     SERIAL_CONFIG_OUT,
    output logic [CFG_BITS-1:0]      ACTIVE_CONFIG,
    output ccdl_ext_ctrl_type        EXT_CTRL
);
    ccdl_link_type         link_raw;
    ccdl_link_type         link_s;
    logic                  sclk_rise;
    logic                  apply_rise;
    logic                  shift_step;
    logic                  apply_evt;
    logic                  apply_bad;
    logic [CFG_BITS-1:0]   shift_reg;
    logic [CFG_BITS-1:0]   dyn_cfg;
    logic [CFG_BITS-1:0]   next_cfg;
    logic [1:0]            ctrl;
    logic                  eff_mode;
    logic                  applied_flag;
    logic                  proto_err;
    logic [7:0]            bit_count;
    ccdl_link_state_type   link_state;
    ccdl_link_state_type   next_link_state;
    logic                  apb_setup;
    logic                  apb_write;
    logic                  addr_ok;
    logic [31:0]           read_word;
    logic [CFG_PAD-1:0]    dyn_pad;
    logic [CFG_PAD-1:0]    shift_pad;

    // all link pins cross into the CLOCK domain before use
    assign link_raw = '{sclk:     SHIFT_CLOCK,
                        serial_config_in:     SERIAL_CONFIG_IN,
                        shift_en: CONFIG_SHIFT_ENABLE,
                        apply:    CONFIG_APPLY_STROBE,
                        mode:     CONFIG_MODE_SELECT};

    ccdl_sync #(
        .W ($bits(ccdl_link_type))
    ) u_link_sync (
        .clk      (CLOCK),
        .rst_n    (RSTN),
        .async_in (link_raw),
        .sync_out (link_s)
    );

    ccdl_edge u_sclk_edge (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .level (link_s.sclk),
        .rise  (sclk_rise)
    );

    ccdl_edge u_apply_edge (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .level (link_s.apply),
        .rise  (apply_rise)
    );

    // shift only on a shift clock rise while enable is high
    assign shift_step = sclk_rise & link_s.shift_en;
    // an apply strobe seen while shifting is refused and flagged
    assign apply_evt  = apply_rise & ~link_s.shift_en;
    assign apply_bad  = apply_rise & link_s.shift_en;

    // LSB first in at the top, LSB first out at bit 0
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            shift_reg <= '0;
        end else if (shift_step) begin
            shift_reg <= {link_s.serial_config_in, shift_reg[CFG_BITS-1:1]};
        end
    end

    assign SERIAL_CONFIG_OUT = shift_reg[0];

    // applied dynamic image; resync bit always follows the fixed image
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            dyn_cfg <= FIXED_CONFIG;
        end else if (apply_evt) begin
            dyn_cfg             <= shift_reg;
            dyn_cfg[POS_RESYNC] <= FIXED_CONFIG[POS_RESYNC];
        end else begin
            dyn_cfg[POS_RESYNC] <= FIXED_CONFIG[POS_RESYNC];
        end
    end

    // mode comes from the pin unless software overrides it
    assign eff_mode = ctrl[CTRL_SRC_SW] ? ctrl[CTRL_SW_MODE] : link_s.mode;
    assign next_cfg = eff_mode ? dyn_cfg : FIXED_CONFIG;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ACTIVE_CONFIG <= FIXED_CONFIG;
            // decoded controls agree with the active image from reset on
            EXT_CTRL      <= '{mux_select: FIXED_CONFIG[POS_GLMUX_H:POS_GLMUX_L],
                               half_c:     FIXED_CONFIG[POS_HALF_C],
                               half_b:     FIXED_CONFIG[POS_HALF_B],
                               half_a:     FIXED_CONFIG[POS_HALF_A],
                               resync:     FIXED_CONFIG[POS_RESYNC]};
        end else begin
            ACTIVE_CONFIG     <= next_cfg;
            EXT_CTRL.mux_select <= next_cfg[POS_GLMUX_H:POS_GLMUX_L];
            EXT_CTRL.half_c   <= next_cfg[POS_HALF_C];
            EXT_CTRL.half_b   <= next_cfg[POS_HALF_B];
            EXT_CTRL.half_a   <= next_cfg[POS_HALF_A];
            EXT_CTRL.resync   <= next_cfg[POS_RESYNC];
        end
    end

    // link progress: idle, shifting, armed for apply
    always_comb begin
        next_link_state = link_state;
        case (link_state)
            LS_IDLE:  if (link_s.shift_en) next_link_state = LS_SHIFT;
            LS_SHIFT: if (!link_s.shift_en) next_link_state = LS_ARMED;
            LS_ARMED: begin
                if (link_s.shift_en) begin
                    next_link_state = LS_SHIFT;
                end else if (apply_evt) begin
                    next_link_state = LS_IDLE;
                end
            end
            default:  next_link_state = LS_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            link_state <= LS_IDLE;
        end else begin
            link_state <= next_link_state;
        end
    end

    // bits shifted since the last apply, saturating
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bit_count <= '0;
        end else if (apply_evt) begin
            bit_count <= '0;
        end else if (shift_step && bit_count != CNT_MAX) begin
            bit_count <= bit_count + 8'h01;
        end
    end

    // APB slave: one wait-free access phase, registered answer
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_write = PSEL & PENABLE & PREADY & PWRITE;
    assign dyn_pad   = {{(CFG_PAD-CFG_BITS){1'b0}}, dyn_cfg};
    assign shift_pad = {{(CFG_PAD-CFG_BITS){1'b0}}, shift_reg};

    always_comb begin
        addr_ok   = 1'b1;
        read_word = WORD_ZERO;
        case (PADDR)
            OFS_CTRL:    read_word = {30'h0000_0000, ctrl};
            OFS_STATUS: begin
                read_word[ST_MODE]                 = eff_mode;
                read_word[ST_SHIFTING]             = link_s.shift_en;
                read_word[ST_APPLIED]              = applied_flag;
                read_word[ST_PROTO_ERR]            = proto_err;
                read_word[ST_CNT_LO+7:ST_CNT_LO]   = bit_count;
            end
            OFS_ACTIVE0: read_word = dyn_pad[31:0];
            OFS_ACTIVE1: read_word = dyn_pad[63:32];
            OFS_ACTIVE2: read_word = dyn_pad[95:64];
            OFS_SHIFT0:  read_word = shift_pad[31:0];
            OFS_SHIFT1:  read_word = shift_pad[63:32];
            OFS_SHIFT2:  read_word = shift_pad[95:64];
            default:     addr_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= WORD_ZERO;
        end else begin
            PREADY  <= apb_setup;
            PSLVERR <= apb_setup & ~addr_ok;
            if (apb_setup && !PWRITE && addr_ok) begin
                PRDATA <= read_word;
            end else if (apb_setup) begin
                PRDATA <= WORD_ZERO;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= CTRL_RESET;
        end else if (apb_write && PADDR == OFS_CTRL) begin
            ctrl <= PWDATA[1:0];
        end
    end

    // sticky flags: hardware set wins over a write-one clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            applied_flag <= 1'b0;
        end else if (apply_evt) begin
            applied_flag <= 1'b1;
        end else if (apb_write && PADDR == OFS_STATUS && PWDATA[ST_APPLIED]) begin
            applied_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            proto_err <= 1'b0;
        end else if (apply_bad) begin
            proto_err <= 1'b1;
        end else if (apb_write && PADDR == OFS_STATUS && PWDATA[ST_PROTO_ERR]) begin
            proto_err <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    AST_MODE_SELECT: assert property (
        ##1 ACTIVE_CONFIG == ($past(eff_mode) ? $past(dyn_cfg) : FIXED_CONFIG)
    ) else $error("active configuration does not follow mode select");

    AST_FIXED_DEFAULT: assert property (
        !eff_mode |=> ACTIVE_CONFIG == FIXED_CONFIG
    ) else $error("fixed image not used while mode is low");

    AST_SHIFT_STEP: assert property (
        shift_step |=> shift_reg == {$past(link_s.serial_config_in), $past(shift_reg[CFG_BITS-1:1])}
    ) else $error("shift register did not advance by one bit");

    AST_SHIFT_HOLD: assert property (
        !link_s.shift_en |=> $stable(shift_reg)
    ) else $error("shift register changed with shift enable low");

    AST_SERIAL_OUT: assert property (
        shift_step |=> SERIAL_CONFIG_OUT == $past(shift_reg[1])
    ) else $error("serial out did not present the next low bit");

    AST_APPLY_COPY: assert property (
        apply_evt |=> dyn_cfg[POS_RESYNC-1:0] == $past(shift_reg[POS_RESYNC-1:0])
              && dyn_cfg[CFG_BITS-1:POS_RESYNC+1] == $past(shift_reg[CFG_BITS-1:POS_RESYNC+1])
    ) else $error("apply strobe did not copy the shift register");

    AST_RESYNC_FIXED: assert property (
        ##1 dyn_cfg[POS_RESYNC] == FIXED_CONFIG[POS_RESYNC]
    ) else $error("resync enable bit was altered by loading");

    AST_REFUSE_APPLY: assert property (
        apply_bad |=> $stable(dyn_cfg) && proto_err
    ) else $error("apply during shifting was not refused");

    AST_EXT_DECODE: assert property (
        ##1 EXT_CTRL.mux_select == ACTIVE_CONFIG[POS_GLMUX_H:POS_GLMUX_L]
            && EXT_CTRL.half_a == ACTIVE_CONFIG[POS_HALF_A]
            && EXT_CTRL.half_c == ACTIVE_CONFIG[POS_HALF_C]
            && EXT_CTRL.half_b == ACTIVE_CONFIG[POS_HALF_B]
            && EXT_CTRL.resync == ACTIVE_CONFIG[POS_RESYNC]
    ) else $error("extended controls disagree with active image");

    AST_APB_ANSWER: assert property (
        apb_setup |=> PREADY ##1 !PREADY
    ) else $error("APB answer not one cycle after setup");

    AST_APB_ERROR: assert property (
        apb_setup && !addr_ok |=> PSLVERR && PREADY && PRDATA == WORD_ZERO
    ) else $error("unmapped address not answered with an error");

    AST_LINK_SHIFTING: assert property (
        shift_step |=> link_state == LS_SHIFT
    ) else $error("link state not shifting after a shift step");

    AST_LINK_ARMED: assert property (
        link_state == LS_SHIFT && !link_s.shift_en |=> link_state == LS_ARMED
    ) else $error("link state not armed after shift enable fell");

    AST_APPLY_FLAG: assert property (
        apply_evt |=> applied_flag && bit_count == '0
    ) else $error("apply did not set the flag and clear the bit count");

endmodule : ccdl_loader
`default_nettype wire

// [hdl/ccdl_pkg.sv]
// package: constants and types for the clock conditioner dynamic configuration loader
//
// Notes on behaviour
// - mode select high takes dynamic configuration, low takes fixed programmed bits
// - shift register holds control bits 0..80, each group at a fixed position
// - shift register contents leave on serial out, LSB first, for readback
// - one bit shifts per shift clock only while shift enable is high
// - apply strobe after shifting copies shift register into active configuration
// - user logic alone controls the serial ports; no reprogramming needed
// - extended variant adds bits 81..88; bits 88:87 select glitchless mux inputs
// - bits 84, 85, 86 enable half divide of oscillator when bypassed
// - bit 80 enables divider resync and is never changed by dynamic loading
// - fixed programmed bits never change and define the default state
package ccdl_pkg;

    localparam int CFG_BITS  = 89;
    localparam int BASE_BITS = 81;
    localparam int CFG_PAD   = 96;

    localparam int POS_RESYNC  = 80;
    localparam int POS_HALF_A  = 84;
    localparam int POS_HALF_B  = 85;
    localparam int POS_HALF_C  = 86;
    localparam int POS_GLMUX_L = 87;
    localparam int POS_GLMUX_H = 88;

    // fixed programmed image; only the resync enable is set by default
    localparam logic [CFG_BITS-1:0] CFG_FIXED_DEFAULT = 89'h001_0000_0000_0000_0000_0000;

    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STATUS   = 12'h004;
    localparam logic [11:0] OFS_ACTIVE0  = 12'h008;
    localparam logic [11:0] OFS_ACTIVE1  = 12'h00C;
    localparam logic [11:0] OFS_ACTIVE2  = 12'h010;
    localparam logic [11:0] OFS_SHIFT0   = 12'h014;
    localparam logic [11:0] OFS_SHIFT1   = 12'h018;
    localparam logic [11:0] OFS_SHIFT2   = 12'h01C;

    localparam int CTRL_SRC_SW  = 0;
    localparam int CTRL_SW_MODE = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int ST_MODE      = 0;
    localparam int ST_SHIFTING  = 1;
    localparam int ST_APPLIED   = 2;
    localparam int ST_PROTO_ERR = 3;
    localparam int ST_CNT_LO    = 8;

    localparam logic [7:0]  CNT_MAX  = 8'hFF;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        LS_IDLE  = 2'b00,
        LS_SHIFT = 2'b01,
        LS_ARMED = 2'b10
    } ccdl_link_state_type;

    typedef struct packed {
        logic [1:0] mux_select;
        logic       half_c;
        logic       half_b;
        logic       half_a;
        logic       resync;
    } ccdl_ext_ctrl_type;

    typedef struct packed {
        logic sclk;
        logic serial_config_in;
        logic shift_en;
        logic apply;
        logic mode;
    } ccdl_link_type;

endpackage : ccdl_pkg

// [hdl/ccdl_sync.sv]
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module ccdl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : ccdl_sync
`default_nettype wire

// [hdl/ccdl_edge.sv]
// rising edge detector on a synchronised level
`timescale 1ns/1ps
`default_nettype none
module ccdl_edge (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level,
    output logic      rise
);
    logic prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
endmodule : ccdl_edge

// [dv/ccdl_link_model.sv]
// behavioural serial controller that loads the configuration shift register
`timescale 1ns/1ps
`default_nettype none
module ccdl_link_model
    import ccdl_pkg::*;
(
    output logic sclk,
    output logic serial_config_in,
    output logic shift_en,
    output logic apply,
    input  wire logic sout
);
    logic [CFG_BITS-1:0] readback;

    initial begin
        sclk     = 1'b0;
        serial_config_in     = 1'b0;
        shift_en = 1'b0;
        apply    = 1'b0;
    end

    // bad raises the strobe mid-frame; extra pulses the clock with enable low
    task automatic send(input logic [CFG_BITS-1:0] img, input logic bad, input int extra);
        #3;
        shift_en = 1'b1;
        for (int i = 0; i < CFG_BITS; i++) begin
            serial_config_in = img[i];
            #80;
            readback[i] = sout;
            sclk = 1'b1;
            if (bad && i == 40) begin
                apply = 1'b1;
            end
            #80;
            sclk = 1'b0;
            if (bad && i == 41) begin
                apply = 1'b0;
            end
        end
        #80;
        shift_en = 1'b0;
        serial_config_in = ~serial_config_in;
        repeat (extra) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #160;
        if (!bad) begin
            apply = 1'b1;
            #160;
            apply = 1'b0;
        end
        #160;
    endtask : send
endmodule : ccdl_link_model
`default_nettype wire

// [dv/ccdl_loader_test.sv]
// self-checking bench for the dynamic configuration loader
`timescale 1ns/1ps
`default_nettype none
module ccdl_loader_test;
    import ccdl_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } ccdl_note_type;
    logic                clock, rstn, psel, penable, pwrite, mode;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, seed;
    logic                pready, pslverr, sclk, serial_config_in, shift_en, apply, sout;
    logic [CFG_BITS-1:0] active, img, exp_img, last_img;
    ccdl_ext_ctrl_type   ext;
    ccdl_note_type       notes[$];
    int                  bad_count = 0;
    int                  n_tests = 0;

    ccdl_loader u_dut (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SHIFT_CLOCK(sclk), .SERIAL_CONFIG_IN(serial_config_in),
        .CONFIG_SHIFT_ENABLE(shift_en), .CONFIG_APPLY_STROBE(apply),
        .CONFIG_MODE_SELECT(mode), .SERIAL_CONFIG_OUT(sout), .ACTIVE_CONFIG(active),
        .EXT_CTRL(ext));
    ccdl_link_model u_link (.sclk(sclk), .serial_config_in(serial_config_in), .shift_en(shift_en), .apply(apply),
        .sout(sout));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift

    task print_verdict;
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [CFG_PAD-1:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, m,
                       input logic e);
        int n;
        n = 0;
        notes.push_back('{d, m, e});
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            print_verdict();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic read3(input logic [11:0] base, input logic [CFG_BITS-1:0] v);
        logic [CFG_PAD-1:0] w;
        w = CFG_PAD'(v);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, base + 12'(4 * k), w[32*k +: 32], 32'hFFFF_FFFF, 1'b0);
        end
    endtask : read3

    // takes the oldest note whenever a transfer completes
    always @(posedge clock) begin : monitor
        ccdl_note_type nt;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            nt = notes.pop_front();
            n_tests++;
            if (pslverr !== nt.err || (prdata & nt.mask) !== (nt.data & nt.mask)) begin
                bad_count++;
                $display("mismatch apb %h expected %h seen %h", paddr, nt.data, prdata);
            end
        end
    end

    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    initial begin
        rstn    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        mode    = 1'b0;
        seed    = 32'h0000_e3bb;
        img     = '0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check("active", CFG_PAD'(CFG_FIXED_DEFAULT), CFG_PAD'(active));
        check("ext", CFG_PAD'(6'h01), CFG_PAD'(ext));
        last_img = '0;
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3; j++) begin
                seed = xorshift(seed);
                img = {img[CFG_BITS-33:0], seed};
            end
            exp_img = img;
            exp_img[POS_RESYNC] = CFG_FIXED_DEFAULT[POS_RESYNC];
            u_link.send(img, 1'b0, 2 * k);
            repeat (4) @(posedge clock);
            check("readback", CFG_PAD'(last_img), CFG_PAD'(u_link.readback));
            read3(OFS_SHIFT0, img);
            read3(OFS_ACTIVE0, exp_img);
            if (k == 0) begin
                check("active", CFG_PAD'(CFG_FIXED_DEFAULT), CFG_PAD'(active));
                mode <= 1'b1;
                repeat (6) @(posedge clock);
            end
            check("active", CFG_PAD'(exp_img), CFG_PAD'(active));
            check("ext", CFG_PAD'({exp_img[POS_GLMUX_H:POS_GLMUX_L], exp_img[POS_HALF_C],
                exp_img[POS_HALF_B], exp_img[POS_HALF_A], exp_img[POS_RESYNC]}),
                CFG_PAD'(ext));
            last_img = img;
        end
        u_link.send(~last_img, 1'b1, 0);
        repeat (4) @(posedge clock);
        check("active", CFG_PAD'(exp_img), CFG_PAD'(active));
        check("readback", CFG_PAD'(last_img), CFG_PAD'(u_link.readback));
        read3(OFS_SHIFT0, ~last_img);
        apb(1'b0, OFS_STATUS, 32'h0000_590D, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, OFS_STATUS, 32'h0000_0008, 32'h0000_0000, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0000_5905, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, 12'h100, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, 12'h100, 32'h0000_0003, 32'h0000_0000, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0000_0001, 32'h0000_0000, 1'b0);
        apb(1'b0, OFS_CTRL, 32'h0000_0001, 32'h0000_0003, 1'b0);
        repeat (6) @(posedge clock);
        check("active", CFG_PAD'(CFG_FIXED_DEFAULT), CFG_PAD'(active));
        print_verdict();
    end
endmodule : ccdl_loader_test
`default_nettype wire
